// >>> hdl/csl_top.sv
`timescale 1ns/1ps
module csl_top
   import csl_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int CUT_MS = OC_CUT_MS,
   parameter int RETRY_MS = OC_RETRY_MS
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [5:0] bus_addr_i,
   input wire logic [7:0] bus_wdata_i,
   input wire logic bus_we_i,
   input wire logic bus_re_i,
   output logic [7:0] bus_rdata_o,
   input wire csl_sense_t sense_i,
   input wire logic alert_pin_i,
   output logic alert_pin_o,
   output logic alert_pin_oe_o,
   output csl_power_t power_o
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0] r1;          // control 1
      logic [7:0] r3;          // limits
      logic [7:0] r5;          // timer control
      logic [7:0] r6;          // alert masks
      logic [7:0] r7;          // supervisor control
      logic [7:0] ra;          // misc
      logic wd_fault;          // host_timeout_fault
      logic [4:0] faults;      // fault record
      logic host_mode;         // host has programmed us
      logic [7:0] rdata;       // read answer
      logic [2:0] pin_sync;    // alert pin synchroniser
      logic pin_low;           // agreed pin level
      logic [15:0] tick_cnt;   // cycle prescaler
      logic ms_tick;           // one per tick
      logic [9:0] ms_cnt;      // ticks within second
      logic sec_tick;          // one per second
      logic [14:0] press_cnt;  // press length in ms
      csl_rcy_t rcy;           // recycle state
      logic rcy_long;          // off-time latched at start
      logic [11:0] rcy_cnt;    // off-time in ms
      logic [7:0] wd_cnt;      // watchdog seconds
      logic [15:0] safety_cnt; // safety seconds
      logic timer_fault;       // safety expiry
      csl_oc_t oc;             // overcurrent state
      logic [15:0] oc_cnt;     // overcurrent ms
      logic alert_drive;       // pulling alert low
      logic [11:0] alert_cnt;  // pulse cycles
      logic in_good_q;         // previous input_good
      logic bat_q;             // previous bat_present
      logic chg_q;             // previous charging
      logic pre_q;             // previous precharge
      logic uvov_q;            // previous input_uvov
      logic done_q;            // previous charge_done
      csl_power_t pwr;         // registered controls
   } csl_state_t;

   csl_state_t s;      // current state
   csl_state_t next_s; // next state

   // ****************************************
   // helpers
   // ****************************************
   // watchdog limit in seconds per field code
   function automatic logic [7:0] wd_limit(input logic [1:0] code);
      wd_limit = 8'((WD_STEP_S << code) >> 1);
   endfunction

   // main-phase safety limit in seconds
   function automatic logic [15:0] chg_limit(input logic [1:0] code);
      case (code)
         2'h0: chg_limit = 16'(CHG_LIMIT_H0 * SEC_PER_HOUR);
         2'h1: chg_limit = 16'(CHG_LIMIT_H1 * SEC_PER_HOUR);
         2'h2: chg_limit = 16'(CHG_LIMIT_H2 * SEC_PER_HOUR);
         default: chg_limit = 16'(CHG_LIMIT_H3 * SEC_PER_HOUR);
      endcase
   endfunction

   // rising edge of a sampled level
   function automatic logic rose(input logic now, input logic prev);
      rose = now & ~prev;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic mapped;        // aligned, in range
      logic [3:0] idx;     // register index
      logic restart;       // safety timer restart
      logic to_default;    // enter default mode
      logic start_rcy;     // begin power recycle
      logic kick;          // watchdog kick
      logic wd_run;        // watchdog running
      logic wd_expire;     // watchdog expired
      logic want_chg;      // charging requested
      logic ntc_out;       // window fault in charge
      logic board_hot;     // board overtemperature
      logic charging;      // charging now
      logic uv;            // battery undervoltage
      logic oc_high;       // current above limit
      logic sw_mode;       // switch mode active
      logic bat_path;      // path wants battery switch
      logic [4:0] cond;    // live fault conditions
      logic [4:0] ev;      // alert events
      mapped = 1'b0;
      idx = 4'h0;
      restart = 1'b0;
      to_default = 1'b0;
      start_rcy = 1'b0;
      kick = 1'b0;
      wd_run = 1'b0;
      wd_expire = 1'b0;
      want_chg = 1'b0;
      ntc_out = 1'b0;
      board_hot = 1'b0;
      charging = 1'b0;
      uv = 1'b0;
      oc_high = 1'b0;
      sw_mode = 1'b0;
      bat_path = 1'b0;
      cond = 5'h00;
      ev = 5'h00;
      next_s = s;
      next_s.rdata = 8'h00;
      next_s.ms_tick = 1'b0;
      next_s.sec_tick = 1'b0;

      // time base
      if (s.tick_cnt == 16'(TICK_CYC - 1)) begin
         next_s.tick_cnt = 16'h0000;
         next_s.ms_tick = 1'b1;
      end else begin
         next_s.tick_cnt = s.tick_cnt + 16'h0001;
      end
      if (s.ms_tick) begin
         if (s.ms_cnt == 10'(MS_PER_SEC - 1)) begin
            next_s.ms_cnt = 10'h000;
            next_s.sec_tick = 1'b1;
         end else begin
            next_s.ms_cnt = s.ms_cnt + 10'h001;
         end
      end

      // alert pin as input: level counts once stages two and three agree
      next_s.pin_sync = {s.pin_sync[1:0], alert_pin_i};
      if (s.pin_sync[2] == s.pin_sync[1]) begin
         next_s.pin_low = ~s.pin_sync[2];
      end

      // temperature handling
      want_chg = sense_i.input_good & ~s.r1[B_CHG_DIS] & (s.rcy == CSL_RUN);
      ntc_out = s.r7[B_THERM_EN] & s.r7[B_BOARD_SEL] & want_chg
         & (sense_i.therm_hot | sense_i.therm_cold);
      board_hot = s.r7[B_THERM_EN] & ~s.r7[B_BOARD_SEL] & sense_i.therm_hot;
      charging = want_chg & ~ntc_out & ~board_hot & ~s.timer_fault
         & ~sense_i.bat_ovp & ~sense_i.charge_done & sense_i.bat_present;

      // register writes
      mapped = (bus_addr_i[1:0] == 2'h0);
      idx = bus_addr_i[5:2];
      if (bus_we_i & mapped) begin
         next_s.host_mode = 1'b1;
         case (idx)
            REG_CTRL1: begin
               restart = s.r1[B_CHG_DIS] & ~bus_wdata_i[B_CHG_DIS];
               next_s.r1 = bus_wdata_i;
            end
            REG_CHGCUR: begin
               kick = bus_wdata_i[B_KICK];
               restart = bus_wdata_i[B_KICK];
            end
            REG_LIMITS: begin
               next_s.r3 = {bus_wdata_i[7:B_OCLIM], 4'h0};
            end
            REG_TIMER: begin
               restart = ~s.r5[B_TMR_EN] & bus_wdata_i[B_TMR_EN];
               next_s.r5 = {4'h0, bus_wdata_i[3:0]};
            end
            REG_MASK: begin
               next_s.r6 = {3'h0, bus_wdata_i[4:0]};
            end
            REG_SUPV: begin
               to_default = bus_wdata_i[B_REG_RST];
               next_s.r7 = {1'b0, bus_wdata_i[6:0]};
            end
            REG_MISC: begin
               start_rcy = bus_wdata_i[B_RECYCLE];
               restart = bus_wdata_i[B_RECYCLE];
               next_s.ra = {4'h0, bus_wdata_i[B_SW_MODE], 3'h0};
            end
            default: begin
               next_s.host_mode = s.host_mode;
            end
         endcase
      end

      // register reads, answer in the next cycle
      if (bus_re_i & mapped) begin
         case (idx)
            REG_CTRL1: next_s.rdata = s.r1;
            REG_LIMITS: next_s.rdata = s.r3;
            REG_TIMER: next_s.rdata = s.r5;
            REG_MASK: next_s.rdata = s.r6;
            REG_SUPV: next_s.rdata = s.r7;
            REG_STATUS: next_s.rdata = {s.wd_fault, 7'h00};
            REG_FAULT: next_s.rdata = {3'h0, s.faults};
            REG_MISC: next_s.rdata = s.ra;
            default: next_s.rdata = 8'h00;
         endcase
      end

      // watchdog
      wd_run = s.host_mode & (s.r7[1:B_WD_FLD] != 2'h0)
         & (sense_i.input_good | s.r7[B_WD_DIS]);
      if (kick | ~wd_run) begin
         next_s.wd_cnt = 8'h00;
      end else if (s.wd_cnt >= wd_limit(s.r7[1:B_WD_FLD])) begin
         wd_expire = 1'b1;
         start_rcy = 1'b1;
         to_default = 1'b1;
      end else if (s.sec_tick) begin
         next_s.wd_cnt = s.wd_cnt + 8'h01;
      end

      // other default mode events
      if (rose(sense_i.input_good, s.in_good_q) & ~sense_i.bat_present) begin
         to_default = 1'b1;
      end
      if (rose(sense_i.bat_present, s.bat_q) & ~sense_i.input_good) begin
         to_default = 1'b1;
      end

      // switch mode clears on input return or battery change with input
      if (rose(sense_i.input_good, s.in_good_q)
         | ((sense_i.bat_present ^ s.bat_q) & sense_i.input_good)) begin
         next_s.ra[B_SW_MODE] = 1'b0;
      end

      // defaults take over all software settings
      if (to_default) begin
         next_s.r1 = CTRL1_DEF;
         next_s.r3 = LIMITS_DEF;
         next_s.r5 = TIMER_DEF;
         next_s.r6 = 8'h00;
         next_s.r7 = SUPV_DEF;
         next_s.ra = 8'h00;
         next_s.host_mode = 1'b0;
         next_s.wd_cnt = 8'h00;
      end

      // long press on the alert pin, ignored while we drive it
      if (~s.pin_low | s.alert_drive | (s.rcy != CSL_RUN)) begin
         next_s.press_cnt = 15'h0000;
      end else if (s.press_cnt >= 15'((PRESS_BASE_S + PRESS_STEP_S * s.r1[7:B_PRESS]) * MS_PER_SEC)) begin
         start_rcy = 1'b1;
         next_s.press_cnt = 15'h0000;
      end else if (s.ms_tick) begin
         next_s.press_cnt = s.press_cnt + 15'h0001;
      end

      // power recycle sequencer
      case (s.rcy)
         CSL_RUN: begin
            if (start_rcy) begin
               next_s.rcy = CSL_OFF;
               next_s.rcy_long = s.r1[B_OFFTIME];
               next_s.rcy_cnt = 12'h000;
            end
         end
         CSL_OFF: begin
            if (s.rcy_cnt >= 12'((s.rcy_long ? RECYCLE_LONG_S : RECYCLE_SHORT_S) * MS_PER_SEC)) begin
               next_s.rcy = CSL_RUN;
            end else if (s.ms_tick) begin
               next_s.rcy_cnt = s.rcy_cnt + 12'h001;
            end
         end
         default: begin
            next_s.rcy = CSL_RUN;
         end
      endcase

      // safety timer
      if (sense_i.new_cycle | (s.pre_q & ~sense_i.precharge & charging)) begin
         restart = 1'b1;
      end
      if (restart) begin
         next_s.safety_cnt = 16'h0000;
         next_s.timer_fault = 1'b0;
      end else if (charging & s.r5[B_TMR_EN] & s.sec_tick) begin
         next_s.safety_cnt = s.safety_cnt + 16'h0001;
      end
      if (charging & s.r5[B_TMR_EN]) begin
         if (sense_i.precharge ? (s.safety_cnt >= 16'(PRECHARGE_LIMIT_H * SEC_PER_HOUR))
            : (s.safety_cnt >= chg_limit(s.r5[2:B_CHG_LIM]))) begin
            next_s.timer_fault = 1'b1;
         end
      end

      // overcurrent in discharge or supplement
      sw_mode = s.ra[B_SW_MODE];
      oc_high = (sense_i.bat_current > s.r3[7:B_OCLIM]) & ~charging & ~sw_mode;
      case (s.oc)
         CSL_OC_ON: begin
            next_s.oc_cnt = 16'h0000;
            if (oc_high) begin
               next_s.oc = CSL_OC_WAIT;
            end
         end
         CSL_OC_WAIT: begin
            if (~oc_high) begin
               next_s.oc = CSL_OC_ON;
            end else if (s.oc_cnt >= 16'(CUT_MS)) begin
               next_s.oc = CSL_OC_OPEN;
               next_s.oc_cnt = 16'h0000;
            end else if (s.ms_tick) begin
               next_s.oc_cnt = s.oc_cnt + 16'h0001;
            end
         end
         CSL_OC_OPEN: begin
            if (s.oc_cnt >= 16'(RETRY_MS)) begin
               next_s.oc = CSL_OC_ON;
            end else if (s.ms_tick) begin
               next_s.oc_cnt = s.oc_cnt + 16'h0001;
            end
         end
         default: begin
            next_s.oc = CSL_OC_ON;
         end
      endcase

      // fault record: bits 0 to 3 latch until read, bit 4 follows its live condition
      cond = {ntc_out | board_hot, sense_i.bat_ovp, s.timer_fault, sense_i.die_hot, sense_i.input_uvov};
      for (int i = 0; i < 4; i++) begin
         next_s.faults[i] = cond[i] | (s.faults[i] & ~(bus_re_i & mapped & (idx == REG_FAULT)));
      end
      next_s.faults[4] = cond[4];
      next_s.wd_fault = wd_expire
         | (s.wd_fault & ~(bus_re_i & mapped & (idx == REG_STATUS)));

      // alert pulse events
      ev[0] = rose(sense_i.input_good, s.in_good_q);
      ev[1] = rose(sense_i.input_uvov, s.uvov_q);
      ev[2] = rose(sense_i.charge_done, s.done_q);
      ev[3] = charging ^ s.chg_q;
      ev[4] = (|(cond & ~s.faults)) | wd_expire;
      if (|(ev & ~s.r6[4:0])) begin
         next_s.alert_drive = 1'b1;
         next_s.alert_cnt = 12'h000;
      end else if (s.alert_drive) begin
         if (s.alert_cnt == 12'(ALERT_PULSE_CYCLES - 1)) begin
            next_s.alert_drive = 1'b0;
         end else begin
            next_s.alert_cnt = s.alert_cnt + 12'h001;
         end
      end

      // edge history
      next_s.in_good_q = sense_i.input_good;
      next_s.bat_q = sense_i.bat_present;
      next_s.chg_q = charging;
      next_s.pre_q = sense_i.precharge;
      next_s.uvov_q = sense_i.input_uvov;
      next_s.done_q = sense_i.charge_done;

      // power stage controls
      uv = sense_i.bat_level < s.r1[2:0];
      bat_path = sense_i.input_good ? (charging | sense_i.supplement) : 1'b1;
      next_s.pwr.bat_sw = (s.rcy == CSL_RUN) & ~board_hot & ~sense_i.sys_short
         & sense_i.bat_present & bat_path
         & (sw_mode | (~uv & (s.oc != CSL_OC_OPEN)));
      next_s.pwr.input_sw = ~s.r1[B_IN_OFF] & (s.rcy == CSL_RUN) & ~board_hot;
      next_s.pwr.charge_en = charging;
      next_s.pwr.divider_en = sense_i.input_good | s.r7[B_DIV_KEEP];
      next_s.pwr.input_ilim = sense_i.sys_short;
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s <= '0;
         s.r1 <= CTRL1_DEF;
         s.r3 <= LIMITS_DEF;
         s.r5 <= TIMER_DEF;
         s.r7 <= SUPV_DEF;
         s.pin_sync <= 3'h7;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from flip-flops, alert data tied low
   assign bus_rdata_o = s.rdata;
   assign power_o = s.pwr;
   assign alert_pin_o = 1'b0;
   assign alert_pin_oe_o = s.alert_drive;

endmodule // csl_top

// >>> inc/csl_pkg.sv
package csl_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;           // system clock period
   localparam int TICK_PERIOD_US = 1000;         // base time tick
   localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
   localparam int MS_PER_SEC = 1000;             // ticks per second
   localparam int SEC_PER_HOUR = 3600;           // seconds per hour
   localparam int ALERT_PULSE_US = 256;          // alert low pulse width
   localparam int ALERT_PULSE_CYCLES = (ALERT_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OC_CUT_MS = 16;                // overcurrent cut delay
   localparam int OC_RETRY_MS = 64;              // overcurrent retry delay
   localparam int PRECHARGE_LIMIT_H = 1;         // pre-charge limit
   localparam int RECYCLE_SHORT_S = 2;           // recycle off-time, bit 0
   localparam int RECYCLE_LONG_S = 4;            // recycle off-time, bit 1
   localparam int PRESS_BASE_S = 8;              // press time offset
   localparam int PRESS_STEP_S = 4;              // press time step
   localparam int WD_STEP_S = 40;                // watchdog time for code 01
   localparam int CHG_LIMIT_H0 = 3;              // main-phase limits
   localparam int CHG_LIMIT_H1 = 5;
   localparam int CHG_LIMIT_H2 = 8;
   localparam int CHG_LIMIT_H3 = 12;

   // ****************************************
   // register indices (byte address = 4 * index)
   // ****************************************
   localparam logic [3:0] REG_CTRL1 = 4'h1;
   localparam logic [3:0] REG_CHGCUR = 4'h2;
   localparam logic [3:0] REG_LIMITS = 4'h3;
   localparam logic [3:0] REG_TIMER = 4'h5;
   localparam logic [3:0] REG_MASK = 4'h6;
   localparam logic [3:0] REG_SUPV = 4'h7;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_FAULT = 4'h9;
   localparam logic [3:0] REG_MISC = 4'hA;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] CTRL1_DEF = 8'hAC;
   localparam logic [7:0] LIMITS_DEF = 8'h80;
   localparam logic [7:0] TIMER_DEF = 8'h0A;
   localparam logic [7:0] SUPV_DEF = 8'h40;

   // ****************************************
   // field positions
   // ****************************************
   localparam int B_PRESS = 6;       // ctrl1 [7:6] press time
   localparam int B_OFFTIME = 5;     // ctrl1 recycle off-time
   localparam int B_IN_OFF = 4;      // ctrl1 input_path_off
   localparam int B_CHG_DIS = 3;     // ctrl1 charge_disable
   localparam int B_KICK = 7;        // chgcur host_timer_kick
   localparam int B_OCLIM = 4;       // limits [7:4]
   localparam int B_TMR_EN = 3;      // timer enable
   localparam int B_CHG_LIM = 1;     // timer [2:1]
   localparam int B_REG_RST = 7;     // supv register reset
   localparam int B_THERM_EN = 6;    // supv thermistor_check_enable
   localparam int B_BOARD_SEL = 5;   // supv board_overtemp_select
   localparam int B_DIV_KEEP = 4;    // supv divider_supply_keep
   localparam int B_WD_DIS = 3;      // supv timeout_in_discharge_enable
   localparam int B_WD_FLD = 0;      // supv [1:0] timeout field
   localparam int B_WD_FAULT = 7;    // status host_timeout_fault
   localparam int B_RECYCLE = 4;     // misc software recycle
   localparam int B_SW_MODE = 3;     // misc switch mode

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [0:0] {CSL_RUN = 1'b0, CSL_OFF = 1'b1} csl_rcy_t;
   typedef enum logic [1:0] {CSL_OC_ON = 2'b00, CSL_OC_WAIT = 2'b01, CSL_OC_OPEN = 2'b11} csl_oc_t;

   // analog comparator results, same clock
   typedef struct packed {
      logic input_good;     // input inside window
      logic input_uvov;     // input under/over voltage
      logic bat_present;    // battery connected
      logic [2:0] bat_level; // battery voltage code
      logic [3:0] bat_current; // discharge current code
      logic precharge;      // battery below pre-charge level
      logic new_cycle;      // new charge cycle pulse
      logic charge_done;    // termination reached
      logic supplement;     // battery assisting input
      logic therm_hot;      // sensed voltage below hot level
      logic therm_cold;     // sensed voltage above cold level
      logic die_hot;        // junction thermal fault
      logic bat_ovp;        // battery over-voltage
      logic sys_short;      // system output shorted
   } csl_sense_t;

   // power stage controls
   typedef struct packed {
      logic input_sw;       // input switch on
      logic bat_sw;         // battery switch on
      logic charge_en;      // charging allowed
      logic divider_en;     // divider supply driven
      logic input_ilim;     // input current limiting
   } csl_power_t;

endpackage

// >>> tb/csl_top_asserts.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module csl_top_asserts
   import csl_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic bus_re_i,
   input wire logic [7:0] bus_rdata_o,
   input wire csl_sense_t sense_i,
   input wire logic alert_pin_o,
   input wire logic alert_pin_oe_o,
   input wire csl_power_t power_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   int low_cnt; // length of the running alert pulse
   // count cycles the device pulls the alert wire
   always_ff @(posedge sys_clk_i) low_cnt <= alert_pin_oe_o ? low_cnt + 1 : 0;
   property p_rst0; $fell(sys_rst_i) |-> power_o == '0 && !alert_pin_oe_o; endproperty
   a_rst0: assert property (p_rst0) else $error("outputs live in reset");
   property p_rst1; $fell(sys_rst_i) && !sense_i.therm_hot |=> power_o.input_sw && !power_o.charge_en; endproperty
   a_rst1: assert property (p_rst1) else $error("bad state after reset");
   property p_scut; sense_i.sys_short |=> !power_o.bat_sw; endproperty
   a_scut: assert property (p_scut) else $error("battery path on in short");
   property p_slim; sense_i.sys_short |=> power_o.input_ilim; endproperty
   a_slim: assert property (p_slim) else $error("no input limit in short");
   property p_plen; $fell(alert_pin_oe_o) |-> low_cnt >= ALERT_PULSE_CYCLES; endproperty
   a_plen: assert property (p_plen) else $error("alert pulse short");
   property p_phold; $rose(alert_pin_oe_o) |=> alert_pin_oe_o [*8]; endproperty
   a_phold: assert property (p_phold) else $error("alert pulse broken");
   property p_od; alert_pin_o == 1'b0; endproperty
   a_od: assert property (p_od) else $error("alert data not low");
   property p_rd; !$past(bus_re_i) |-> bus_rdata_o == 8'h00; endproperty
   a_rd: assert property (p_rd) else $error("read data without read");
   c_alert: cover property ($rose(alert_pin_oe_o));
   c_cut: cover property ($fell(power_o.bat_sw));
   c_rcy: cover property ($fell(power_o.input_sw));
endmodule // csl_top_asserts
bind csl_top csl_top_asserts i_csl_top_asserts (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
   .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o), .sense_i(sense_i), .alert_pin_o(alert_pin_o),
   .alert_pin_oe_o(alert_pin_oe_o), .power_o(power_o));

// >>> tb/csl_button.sv
`timescale 1ns/1ps
// push-button on the alert wire, with pull-up
module csl_button (
   input wire logic press_i,
   input wire logic dev_data_i,
   input wire logic dev_oe_i,
   output logic alert_wire_o
);
   // wire is low while either party pulls it
   assign alert_wire_o = !(press_i || (dev_oe_i && !dev_data_i));
endmodule // csl_button

// >>> tb/csl_top_test.sv
`timescale 1ns/1ps
module csl_top_test
   import csl_pkg::*;
;
   localparam int TK = 1; // cycles per ms tick
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [5:0] addr = '0;
   logic [7:0] wdata = '0;
   logic we = 1'b0;
   logic re = 1'b0;
   logic press = 1'b0;
   logic alert_line;
   logic pin_o;
   logic pin_oe;
   logic [7:0] rdata;
   logic [7:0] v;
   csl_sense_t sense = '0;
   csl_sense_t s = '0;
   csl_power_t pwr;
   int miscompares = 0;
   int n_tests = 0;
   int n;
   always #50 sys_clk_i = ~sys_clk_i;
   csl_top #(.TICK_CYC(TK)) i_csl_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bus_addr_i(addr),
      .bus_wdata_i(wdata), .bus_we_i(we), .bus_re_i(re), .bus_rdata_o(rdata), .sense_i(sense),
      .alert_pin_i(alert_line), .alert_pin_o(pin_o), .alert_pin_oe_o(pin_oe), .power_o(pwr));
   csl_button i_csl_button (.press_i(press), .dev_data_i(pin_o), .dev_oe_i(pin_oe), .alert_wire_o(alert_line));
   function logic [7:0] def_val(input logic [3:0] i);
      case (i)
         REG_CTRL1: return CTRL1_DEF;
         REG_LIMITS: return LIMITS_DEF;
         REG_TIMER: return TIMER_DEF;
         REG_SUPV: return SUPV_DEF;
         default: return 8'h00;
      endcase
   endfunction
   function int off_cyc(input logic b);
      return (b ? RECYCLE_LONG_S : RECYCLE_SHORT_S) * MS_PER_SEC * TK;
   endfunction
   function logic sig(input int k);
      return k == 0 ? pwr.input_sw : k == 1 ? pwr.bat_sw : pin_oe;
   endfunction
   task print_verdict;
      if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge sys_clk_i);
      #1;
   endtask
   task sen;
      @(posedge sys_clk_i);
      sense <= s;
   endtask
   task wr(input logic [3:0] i, input logic [7:0] d);
      @(posedge sys_clk_i);
      we <= 1'b1;
      addr <= {i, 2'b00};
      wdata <= d;
      @(posedge sys_clk_i);
      we <= 1'b0;
   endtask
   task rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      re <= 1'b1;
      addr <= a;
      @(posedge sys_clk_i);
      re <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded wait for a level, counting cycles
   task wt(input int k, input logic lvl, input int lim, output int c);
      c = 0;
      while (sig(k) !== lvl) begin
         cyc(1);
         c++;
         if (c > lim) begin
            chk("wait", 0, 1);
            print_verdict;
         end
      end
   endtask
   initial begin
      void'($urandom(32'h7E80));
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         rd({i[3:0], 2'b00}, v);
         chk("reg", def_val(i[3:0]), v);
      end
      rd(6'h05, v);
      chk("unaligned", 8'h00, v);
      s.bat_present = 1'b1;
      s.bat_level = 3'h7;
      s.input_good = 1'b1;
      sen;
      wt(2, 1'b1, 6, n);
      chk("alert delay", 1, n >= 1 && n <= 3);
      wt(2, 1'b0, 3000, n);
      chk("alert width", 1, n >= ALERT_PULSE_CYCLES && n <= ALERT_PULSE_CYCLES + 4);
      wr(REG_MASK, 8'h1F);
      // input loss alone raises no event, so charge done must be masked too
      s.input_good = 1'b0;
      s.charge_done = 1'b1;
      sen;
      n = 0;
      repeat (20) begin
         cyc(1);
         n += pin_oe;
      end
      chk("masked", 0, n);
      for (int i = 0; i < 6; i++) begin
         s.bat_level = i == 0 ? 3'h4 : i == 1 ? 3'h3 : 3'($urandom_range(7, 0));
         sen;
         cyc(3);
         chk("bat_sw", s.bat_level >= 3'h4, pwr.bat_sw);
      end
      chk("divider", 0, pwr.divider_en);
      wr(REG_SUPV, SUPV_DEF | 8'h10);
      cyc(3);
      chk("divider", 1, pwr.divider_en);
      s.bat_level = 3'h7;
      s.bat_current = 4'h8;
      sen;
      cyc(40);
      chk("no trip", 1, pwr.bat_sw);
      s.bat_current = 4'(9 + $urandom_range(6, 0));
      sen;
      wt(1, 1'b0, 40, n);
      chk("cut", 1, n >= OC_CUT_MS * TK && n <= OC_CUT_MS * TK + 4);
      s.bat_current = 4'h0;
      sen;
      wt(1, 1'b1, 100, n);
      chk("retry", 1, n >= OC_RETRY_MS * TK - 6 && n <= OC_RETRY_MS * TK + 4);
      s.input_good = 1'b1;
      s.therm_hot = 1'b1;
      s.die_hot = 1'b1;
      sen;
      cyc(3);
      chk("board cut", 0, pwr.input_sw);
      rd({REG_FAULT, 2'b00}, v);
      chk("faults", 8'h12, v);
      s.therm_hot = 1'b0;
      s.die_hot = 1'b0;
      s.sys_short = 1'b1;
      sen;
      cyc(3);
      chk("resume", 1, pwr.input_sw);
      chk("limit", 1, pwr.input_ilim);
      // die fault gone: first read shows the latch, second sees it cleared
      rd({REG_FAULT, 2'b00}, v);
      chk("latched", 8'h02, v);
      rd({REG_FAULT, 2'b00}, v);
      chk("cleared", 8'h00, v);
      s.sys_short = 1'b0;
      sen;
      for (int b = 1; b >= 0; b--) begin
         wr(REG_CTRL1, {2'b00, b[0], 5'b01100});
         @(posedge sys_clk_i);
         press <= 1'b1;
         wt(0, 1'b0, PRESS_BASE_S * MS_PER_SEC * TK + 20, n);
         chk("press", 1, n >= PRESS_BASE_S * MS_PER_SEC * TK);
         @(posedge sys_clk_i);
         press <= 1'b0;
         wt(0, 1'b1, 5000, n);
         chk("off time", 1, n >= off_cyc(b[0]) - 3 && n <= off_cyc(b[0]) + 4);
      end
      // watchdog at 40 s; a kick after 10 s must push expiry to at least 39 s later
      wr(REG_SUPV, 8'h01);
      cyc(10 * MS_PER_SEC * TK);
      wr(REG_CHGCUR, 8'h80);
      wt(0, 1'b0, 42 * MS_PER_SEC * TK, n);
      chk("watchdog", 1, n >= 39 * MS_PER_SEC * TK);
      rd({REG_STATUS, 2'b00}, v);
      chk("wd fault", 8'h80, v);
      rd({REG_CTRL1, 2'b00}, v);
      chk("defaults", CTRL1_DEF, v);
      print_verdict;
   end
endmodule // csl_top_test
